// *** ser4_cfg.svh ***
`ifndef SER4_CFG_SVH
`define SER4_CFG_SVH

// register word indices; byte address is four times the index
`define SER4_IDX_CTL    10'h098
`define SER4_IDX_DATA   10'h099
`define SER4_IDX_CFG    10'h09A
`define SER4_IDX_RATE   10'h09B
`define SER4_IDX_IST    10'h09C
`define SER4_IDX_IMSK   10'h09D
`define SER4_IDX_IEN    10'h0A8

// serial_control bit positions
`define SER4_B_MHI      7
`define SER4_B_MLO      6
`define SER4_B_MP       5
`define SER4_B_REN      4
`define SER4_B_TB8      3
`define SER4_B_RB8      2
`define SER4_B_TI       1
`define SER4_B_RI       0

// power_control_reg and irq_enable_reg bit positions
`define SER4_B_RDBL     7
`define SER4_B_FESEL    6
`define SER4_B_IEN      4

// status / mask bit positions
`define SER4_B_IST_TX   0
`define SER4_B_IST_RX   1
`define SER4_B_IST_FE   2

// reset values
`define SER4_RATE_RST   16'h0000
`define SER4_CTL_RST    8'h00

// clock divisors and frame counts
`define SER4_M0_SLOW    16'h000C
`define SER4_M0_FAST    16'h0004
`define SER4_M2_SLOW    16'h0040
`define SER4_M2_FAST    16'h0020
`define SER4_OVS        16'h0010
`define SER4_OVS_MID    4'h7
`define SER4_OVS_LAST   4'hF
`define SER4_SYNC_BITS  4'h8
`define SER4_TX_BITS10  4'h9
`define SER4_TX_BITS11  4'hA
`define SER4_RX_LAST10  4'h9
`define SER4_RX_LAST11  4'hA

// bus constants
`define SER4_HSIZE_WORD 3'h2

`endif

// *** ser4_pkg.sv ***
package ser4_pkg;

  typedef enum logic [1:0] {
    SER4_SYNC8,
    SER4_ASYNC10,
    SER4_ASYNC11_FIX,
    SER4_ASYNC11_VAR
  } ser4_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SYNC,
    TX_SEND,
    TX_STOP
  } ser4_tx_st_t;

  typedef enum logic {
    RX_IDLE,
    RX_BITS
  } ser4_rx_st_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [9:0] idx;
  } ser4_ap_t;

endpackage

// *** ser4_tick.sv ***
`timescale 1ns/10ps
module ser4_tick #(
  parameter int W = 16
) (
  input  wire logic         clk_sys, // system clock
  input  wire logic         reset_n, // async reset, active low
  input  wire logic [W-1:0] reload,  // cycles between ticks minus one
  output logic              tick     // one-cycle pulse
);

  logic [W-1:0] cnt;

  // a new reload takes effect at the next wrap, never cuts a count short
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (cnt == '0)
    begin
      cnt  <= reload;
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt - 1'b1;
      tick <= 1'b0;
    end
  end

endmodule

// *** ser4_uart.sv ***
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
`include "ser4_cfg.svh"
module ser4_uart
  import ser4_pkg::*;
(
  input  wire logic        clk_sys,   // system (oscillator) clock
  input  wire logic        reset_n,   // async reset, active low
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // byte address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write when high
  input  wire logic [2:0]  hsize,     // transfer size
  input  wire logic [31:0] hwdata,    // write data
  input  wire logic        hready,    // bus ready
  output logic      [31:0] hrdata,    // read data
  output logic             hreadyout, // slave ready
  output logic             hresp,     // response, always okay
  output logic             txd_out,   // serial out / mode 0 shift clock
  input  wire logic        rxd_in,    // serial in pin level
  output logic             rxd_out,   // mode 0 data out
  output logic             rxd_oe,    // mode 0 data drive enable
  output logic             irq        // level interrupt
);

  ser4_ap_t    ap;
  ser4_mode_t  mode;
  ser4_tx_st_t tx_st;
  ser4_rx_st_t rx_st;

  logic        mode_hi, mode_lo, mp, ren, tb8, rb8, ti, ri, fe;
  logic        fe_sel, rate_dbl, ien;
  logic [15:0] rate_div;
  logic [2:0]  ist, imask;
  logic [7:0]  rx_buf;
  logic        wr_ctl, wr_data;
  logic        tick;
  logic [15:0] next_reload;

  logic [9:0]  sh;
  logic [3:0]  bits, ovs;
  logic        phase, m0_rx, tx_set, m0_rx_done;

  logic        rxd_m, rxd_s, rxd_d;
  logic [8:0]  rsh;
  logic [3:0]  rx_ovs, rx_idx;
  logic        stop_now, rx_ninth, rx_accept, rx_set, fe_set;

  // named so the reset can take just the five software bits it needs
  localparam logic [7:0] CTL_RST = `SER4_CTL_RST;

  assign mode = ser4_mode_t'({mode_hi, mode_lo});

  // ---------------- bus slave ----------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ap        <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready && hsel && htrans[1] && hsize == `SER4_HSIZE_WORD)
      begin
        ap.valid <= 1'b1;
        ap.write <= hwrite;
        ap.idx   <= haddr[11:2];
        if (!hwrite)
          hrdata <= {24'h00_0000, reg_read(haddr[11:2])};
      end
      else
        ap.valid <= 1'b0;
    end
  end

  assign wr_ctl  = ap.valid && ap.write && ap.idx == `SER4_IDX_CTL;
  assign wr_data = ap.valid && ap.write && ap.idx == `SER4_IDX_DATA;

  function automatic logic [7:0] reg_read(input logic [9:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      `SER4_IDX_CTL:  v = {fe_sel ? fe : mode_hi, mode_lo, mp, ren, tb8, rb8, ti, ri};
      `SER4_IDX_DATA: v = rx_buf;
      `SER4_IDX_CFG:  v = {rate_dbl, fe_sel, 6'h00};
      `SER4_IDX_RATE: v = rate_div[7:0];
      `SER4_IDX_IST:  v = {5'h00, ist};
      `SER4_IDX_IMSK: v = {5'h00, imask};
      `SER4_IDX_IEN:  v = {3'h0, ien, 4'h0};
      default:        v = 8'h00;
    endcase
    return v;
  endfunction

  // ---------------- software registers ----------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {mode_hi, mode_lo, mp, ren, tb8} <= CTL_RST[7:3];
      {fe_sel, rate_dbl, ien}          <= 3'h0;
      rate_div                         <= `SER4_RATE_RST;
      imask                            <= 3'h0;
    end
    else
    begin
      if (wr_ctl)
      begin
        if (!fe_sel)
          mode_hi <= hwdata[`SER4_B_MHI];
        mode_lo <= hwdata[`SER4_B_MLO];
        mp      <= hwdata[`SER4_B_MP];
        ren     <= hwdata[`SER4_B_REN];
        tb8     <= hwdata[`SER4_B_TB8];
      end
      if (ap.valid && ap.write && ap.idx == `SER4_IDX_CFG)
      begin
        rate_dbl <= hwdata[`SER4_B_RDBL];
        fe_sel   <= hwdata[`SER4_B_FESEL];
      end
      if (ap.valid && ap.write && ap.idx == `SER4_IDX_RATE)
        rate_div <= {8'h00, hwdata[7:0]};
      if (ap.valid && ap.write && ap.idx == `SER4_IDX_IMSK)
        imask <= hwdata[2:0];
      if (ap.valid && ap.write && ap.idx == `SER4_IDX_IEN)
        ien <= hwdata[`SER4_B_IEN];
    end
  end

  // hardware-set flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {ti, ri, fe, rb8} <= 4'h0;
      rx_buf            <= 8'h00;
      ist               <= 3'h0;
      irq               <= 1'b0;
    end
    else
    begin
      if (tx_set)
        ti <= 1'b1;
      else if (wr_ctl)
        ti <= hwdata[`SER4_B_TI];
      if (rx_set)
        ri <= 1'b1;
      else if (wr_ctl)
        ri <= hwdata[`SER4_B_RI];
      if (fe_set)
        fe <= 1'b1;
      else if (wr_ctl && fe_sel)
        fe <= hwdata[`SER4_B_MHI];
      if (rx_accept)
      begin
        rb8    <= rx_ninth;
        rx_buf <= mode_hi ? rsh[7:0] : rsh[8:1];
      end
      else
      begin
        if (wr_ctl)
          rb8 <= hwdata[`SER4_B_RB8];
        if (m0_rx_done)
          rx_buf <= sh[9:2];
      end
      ist <= (ist & ~((ap.valid && ap.write && ap.idx == `SER4_IDX_IST) ? hwdata[2:0] : 3'h0))
             | {fe_set, rx_set, tx_set};
      irq <= ien && |(ist & imask);
    end
  end

  // ---------------- bit rate ----------------
  // modes 1 and 3 have no internal baud timer: software gives the 16x tick period
  always_comb
  begin
    unique case (mode)
      SER4_SYNC8:
        next_reload = mp ? (`SER4_M0_FAST >> 1) - 16'h0001
                         : (`SER4_M0_SLOW >> 1) - 16'h0001;
      SER4_ASYNC11_FIX:
        next_reload = rate_dbl ? `SER4_M2_FAST / `SER4_OVS - 16'h0001
                               : `SER4_M2_SLOW / `SER4_OVS - 16'h0001;
      SER4_ASYNC10, SER4_ASYNC11_VAR:
        next_reload = rate_div;
    endcase
  end

  ser4_tick #(
    .W (16)
  ) u_tick (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .reload  (next_reload),
    .tick    (tick)
  );

  // ---------------- transmitter and mode 0 engine ----------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_st      <= TX_IDLE;
      sh         <= 10'h3FF;
      bits       <= 4'h0;
      ovs        <= 4'h0;
      phase      <= 1'b0;
      m0_rx      <= 1'b0;
      txd_out    <= 1'b1;
      rxd_out    <= 1'b1;
      rxd_oe     <= 1'b0;
      tx_set     <= 1'b0;
      m0_rx_done <= 1'b0;
    end
    else
    begin
      tx_set     <= 1'b0;
      m0_rx_done <= 1'b0;
      unique case (tx_st)
        TX_IDLE:
        begin
          txd_out <= 1'b1;
          if (wr_data && mode == SER4_SYNC8)
          begin
            tx_st  <= TX_SYNC;
            sh     <= {2'h3, hwdata[7:0]};
            bits   <= `SER4_SYNC_BITS;
            m0_rx  <= 1'b0;
            rxd_oe <= 1'b1;
            phase  <= 1'b0;
          end
          else if (wr_data)
          begin
            tx_st <= TX_SEND;
            sh    <= {mode_hi ? tb8 : 1'b1, hwdata[7:0], 1'b0};
            bits  <= mode_hi ? `SER4_TX_BITS11 : `SER4_TX_BITS10;
            ovs   <= 4'h0;
          end
          else if (mode == SER4_SYNC8 && ren && !ri && !m0_rx_done)
          begin
            tx_st <= TX_SYNC;
            bits  <= `SER4_SYNC_BITS;
            m0_rx <= 1'b1;
            phase <= 1'b0;
          end
        end
        TX_SYNC:
          if (tick)
          begin
            if (!phase)
            begin
              txd_out <= 1'b0;
              phase   <= 1'b1;
              if (!m0_rx)
                rxd_out <= sh[0];
            end
            else
            begin
              // input is sampled on the rising shift clock
              txd_out <= 1'b1;
              phase   <= 1'b0;
              bits    <= bits - 4'h1;
              sh      <= {m0_rx ? rxd_s : 1'b1, sh[9:1]};
              if (bits == 4'h1)
              begin
                tx_st      <= TX_IDLE;
                rxd_oe     <= 1'b0;
                rxd_out    <= 1'b1;
                tx_set     <= !m0_rx;
                m0_rx_done <= m0_rx;
              end
            end
          end
        TX_SEND:
        begin
          txd_out <= sh[0];
          if (tick)
          begin
            ovs <= ovs + 4'h1;
            if (ovs == `SER4_OVS_LAST)
            begin
              sh   <= {1'b1, sh[9:1]};
              bits <= bits - 4'h1;
              if (bits == 4'h1)
              begin
                tx_st  <= TX_STOP;
                tx_set <= 1'b1;
              end
            end
          end
        end
        TX_STOP:
        begin
          txd_out <= 1'b1;
          if (tick)
          begin
            ovs <= ovs + 4'h1;
            if (ovs == `SER4_OVS_LAST)
              tx_st <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- asynchronous receiver ----------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
      rxd_d <= 1'b1;
    end
    else
    begin
      rxd_m <= rxd_in;
      rxd_s <= rxd_m;
      rxd_d <= rxd_s;
    end
  end

  assign stop_now  = rx_st == RX_BITS && tick && rx_ovs == `SER4_OVS_MID
                     && rx_idx == (mode_hi ? `SER4_RX_LAST11 : `SER4_RX_LAST10);
  assign rx_ninth  = mode_hi ? rsh[8] : rxd_s;
  assign fe_set    = stop_now && !rxd_s;
  // the multiprocessor filter drops the frame without setting ri or rb8; a bad stop bit still sets fe
  assign rx_accept = stop_now && !ri && (!mp || rx_ninth);
  assign rx_set    = rx_accept || m0_rx_done;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_st  <= RX_IDLE;
      rx_ovs <= 4'h0;
      rx_idx <= 4'h0;
      rsh    <= 9'h000;
    end
    else
      unique case (rx_st)
        RX_IDLE:
          if (ren && mode != SER4_SYNC8 && rxd_d && !rxd_s)
          begin
            rx_st  <= RX_BITS;
            rx_ovs <= 4'h0;
            rx_idx <= 4'h0;
          end
        RX_BITS:
          if (tick)
          begin
            rx_ovs <= rx_ovs + 4'h1;
            if (rx_ovs == `SER4_OVS_MID)
            begin
              rx_idx <= rx_idx + 4'h1;
              if (rx_idx == 4'h0)
              begin
                // a glitch that is high again by mid start bit is no frame
                if (rxd_s)
                  rx_st <= RX_IDLE;
              end
              else if (stop_now)
                rx_st <= RX_IDLE;
              else
                rsh <= {rxd_s, rsh[8:1]};
            end
          end
      endcase
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_rx_start;
    rx_st == RX_IDLE ##1 rx_st == RX_BITS;
  endsequence

  sequence s_sync_fall;
    $fell(txd_out) && tx_st == TX_SYNC;
  endsequence

  chk_fe_holds: assert property (fe && !(wr_ctl && fe_sel) |=> fe)
    else $error("frame error flag lost without a clear");
  chk_fe_bad_stop: assert property (stop_now && !rxd_s |=> fe && ist[`SER4_B_IST_FE])
    else $error("bad stop bit did not flag a frame error");
  chk_mp_ninth: assert property (stop_now && mode_hi && mp && !rsh[8] && !ri
                                 && !wr_ctl |=> !ri)
    else $error("address filter let a ninth-bit-zero frame through");
  chk_mp_stop: assert property (stop_now && mode == SER4_ASYNC10 && mp && !rxd_s
                                && !ri && !wr_ctl |=> !ri)
    else $error("mode 1 filter let a bad stop frame through");
  chk_sync_fast: assert property (s_sync_fall and mp |-> ##2 $rose(txd_out))
    else $error("fast shift clock half period wrong");
  chk_sync_slow: assert property (s_sync_fall and !mp |-> ##6 $rose(txd_out))
    else $error("slow shift clock half period wrong");
  chk_ren_gate: assert property (s_rx_start |-> $past(ren))
    else $error("reception began while disabled");
  chk_tx_ninth: assert property (tx_st == TX_IDLE && wr_data && mode_hi
                                 |=> sh[9] == $past(tb8))
    else $error("ninth transmit bit not taken from control");
  chk_ti_stop: assert property (tx_set && tx_st == TX_STOP |=> ti && txd_out)
    else $error("tx done not raised at stop bit start");
  chk_rx_half: assert property (stop_now && !mp && !ri |=> ri ##0 rx_st == RX_IDLE)
    else $error("rx done not raised mid stop bit");
  chk_data_split: assert property (wr_data && !rx_set |=> $stable(rx_buf))
    else $error("transmit write disturbed receive data");
  chk_irq_gate: assert property (!ien |=> !irq)
    else $error("interrupt raised while serial enable is off");

endmodule

// *** ser4_remote.sv ***
`timescale 1ns/10ps
module ser4_remote (
  input  wire logic clk_sys,  // system clock
  input  wire logic txd_out,  // device serial out or shift clock
  input  wire logic rxd_out,  // device mode 0 data
  output logic      line_out  // far side drive of the data pin
);
  // the line idles at the marking level between frames
  initial line_out = 1'b1;

  task automatic send(input logic [8:0] d, input int n, input logic stp, input int bc);
    line_out <= 1'b0;
    repeat (bc) @(posedge clk_sys);
    for (int i = 0; i < n; i++)
    begin
      line_out <= d[i];
      repeat (bc) @(posedge clk_sys);
    end
    line_out <= stp;
    repeat (bc) @(posedge clk_sys);
    line_out <= 1'b1;
    repeat (2 * bc) @(posedge clk_sys);
  endtask

  // samples on the falling clock edge so registered outputs have settled
  task automatic grab(input int n, input int bc, output logic [8:0] d, output logic stp);
    d = 9'h000;
    while (txd_out !== 1'b0) @(negedge clk_sys);
    repeat (bc / 2) @(negedge clk_sys);
    for (int i = 0; i < n; i++)
    begin
      repeat (bc) @(negedge clk_sys);
      d[i] = txd_out;
    end
    repeat (bc) @(negedge clk_sys);
    stp = txd_out;
    repeat (bc) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask

  // mode 0 receive: new bit goes out after each falling shift clock
  task automatic send0(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      while (txd_out !== 1'b0) @(negedge clk_sys);
      line_out <= d[i];
      while (txd_out === 1'b0) @(negedge clk_sys);
    end
    @(posedge clk_sys);
    line_out <= 1'b1;
  endtask

  task automatic grab0(output logic [7:0] d, output int lo);
    lo = 0;
    for (int i = 0; i < 8; i++)
    begin
      while (txd_out !== 1'b0) @(negedge clk_sys);
      while (txd_out === 1'b0)
      begin
        if (i == 0)
          lo++;
        @(negedge clk_sys);
      end
      d[i] = rxd_out;
    end
    repeat (4) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask
endmodule

// *** serial_port_four_mode_test.sv ***
`timescale 1ns/10ps
`include "ser4_cfg.svh"
module serial_port_four_mode_test;
  import ser4_pkg::*;
  logic        clk_sys;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        txd_out;
  logic        rxd_out;
  logic        rxd_oe;
  logic        irq;
  logic        line_far;
  wire         rxd_pin;
  int          fails;
  int          n_compared;
  int          cycles;

  // the device wins the shared data pin only while it drives in mode 0
  assign rxd_pin = rxd_oe ? rxd_out : line_far;

  ser4_uart dut_u (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .txd_out   (txd_out),
    .rxd_in    (rxd_pin),
    .rxd_out   (rxd_out),
    .rxd_oe    (rxd_oe),
    .irq       (irq)
  );

  ser4_remote far_u (
    .clk_sys  (clk_sys),
    .txd_out  (txd_out),
    .rxd_out  (rxd_out),
    .line_out (line_far)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t run did not complete", $time);
      finish_test;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic [9:0] i, input logic w, input logic [7:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h00000, i, 2'h0};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(i, 1'b1, d, q);
  endtask

  task automatic rd(input logic [9:0] i, output logic [31:0] q);
    bus(i, 1'b0, 8'h00, q);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    rd(`SER4_IDX_CTL, q);
    check(q, 32'h00000000, "control reset");
    rd(`SER4_IDX_IST, q);
    check(q, 32'h00000000, "status reset");
    rd(10'h0A0, q);
    check(q, 32'h00000000, "unmapped read");
    check({31'h0, hresp}, 32'h0, "okay response");
  endtask

  task automatic t_tx;
    logic [7:0] ctl [4] = '{8'h40, 8'h88, 8'h80, 8'hC8};
    logic [7:0] pc [4] = '{8'h00, 8'h80, 8'h00, 8'h00};
    int bc [4] = '{16, 32, 64, 16};
    logic [8:0] d;
    logic s;
    logic [31:0] q;
    for (int m = 0; m < 4; m++)
    begin
      wr(`SER4_IDX_CFG, pc[m]);
      wr(`SER4_IDX_CTL, ctl[m]);
      fork
        far_u.grab(m == 0 ? 8 : 9, bc[m], d, s);
        wr(`SER4_IDX_DATA, 8'hA5);
      join
      check({23'h0, d}, {23'h0, m == 0 ? 1'b0 : ctl[m][3], 8'hA5}, "tx frame");
      check({31'h0, s}, 32'h1, "tx stop");
      rd(`SER4_IDX_CTL, q);
      check(q, {24'h0, ctl[m] | 8'h02}, "tx done");
    end
  endtask

  task automatic t_mode0;
    logic [7:0] d;
    int lo;
    logic [31:0] q;
    wr(`SER4_IDX_CFG, 8'h00);
    for (int mp = 0; mp < 2; mp++)
    begin
      wr(`SER4_IDX_CTL, mp == 1 ? 8'h20 : 8'h00);
      fork
        far_u.grab0(d, lo);
        wr(`SER4_IDX_DATA, 8'h96);
      join
      check({24'h0, d}, 32'h96, "shift data");
      check(lo, mp == 1 ? 2 : 6, "shift clock low half");
      rd(`SER4_IDX_CTL, q);
      check(q, mp == 1 ? 32'h22 : 32'h02, "shift done");
      check({31'h0, rxd_oe}, 32'h0, "data pin released");
    end
  endtask

  task automatic t_m0rx;
    logic [31:0] q;
    fork
      far_u.send0(8'h6B);
      wr(`SER4_IDX_CTL, 8'h10);
    join
    repeat (4) @(posedge clk_sys);
    rd(`SER4_IDX_CTL, q);
    check(q, 32'h11, "shift receive done");
    rd(`SER4_IDX_DATA, q);
    check(q, 32'h6B, "shift receive data");
    rd(`SER4_IDX_IST, q);
    check(q & 32'h2, 32'h2, "shift receive status");
  endtask

  task automatic t_rx;
    logic [31:0] q;
    logic [8:0] d;
    logic s;
    wr(`SER4_IDX_CTL, 8'h40);
    far_u.send(9'h05A, 8, 1'b1, 16);
    rd(`SER4_IDX_CTL, q);
    check(q, 32'h40, "rx while disabled");
    wr(`SER4_IDX_CTL, 8'h50);
    far_u.send(9'h05A, 8, 1'b1, 16);
    rd(`SER4_IDX_CTL, q);
    check(q, 32'h55, "mode 1 rx");
    rd(`SER4_IDX_DATA, q);
    check(q, 32'h5A, "rx data");
    fork
      far_u.grab(8, 16, d, s);
      wr(`SER4_IDX_DATA, 8'h11);
    join
    rd(`SER4_IDX_DATA, q);
    check(q, 32'h5A, "rx data kept");
    wr(`SER4_IDX_CTL, 8'hF0);
    far_u.send(9'h033, 9, 1'b1, 16);
    rd(`SER4_IDX_CTL, q);
    check(q & 32'h1, 32'h0, "address filter");
    far_u.send(9'h133, 9, 1'b1, 16);
    rd(`SER4_IDX_CTL, q);
    check(q & 32'h5, 32'h5, "address accepted");
    rd(`SER4_IDX_DATA, q);
    check(q, 32'h33, "ninth bit data");
    // mode bits go in before the select flips bit 7 over to the error flag
    wr(`SER4_IDX_CTL, 8'h70);
    wr(`SER4_IDX_CFG, 8'h40);
    far_u.send(9'h0C3, 8, 1'b0, 16);
    rd(`SER4_IDX_CTL, q);
    check(q & 32'h81, 32'h80, "bad stop");
    far_u.send(9'h0C3, 8, 1'b1, 16);
    rd(`SER4_IDX_CTL, q);
    check(q & 32'h81, 32'h81, "error held");
    wr(`SER4_IDX_CTL, 8'h70);
    rd(`SER4_IDX_CTL, q);
    check(q & 32'h81, 32'h0, "error cleared");
    wr(`SER4_IDX_CFG, 8'h00);
    rd(`SER4_IDX_CTL, q);
    check(q & 32'hC0, 32'h40, "mode bits back");
  endtask

  task automatic irq_is(input logic e);
    logic [31:0] q;
    rd(`SER4_IDX_IST, q);
    check({31'h0, irq}, {31'h0, e}, "irq level");
  endtask

  task automatic t_irq;
    logic [31:0] q;
    logic [8:0] d;
    logic s;
    wr(`SER4_IDX_IST, 8'h07);
    rd(`SER4_IDX_IST, q);
    check(q, 32'h0, "status cleared");
    wr(`SER4_IDX_IMSK, 8'h01);
    wr(`SER4_IDX_IEN, 8'h10);
    wr(`SER4_IDX_CTL, 8'h40);
    fork
      far_u.grab(8, 16, d, s);
      wr(`SER4_IDX_DATA, 8'h3C);
    join
    rd(`SER4_IDX_IST, q);
    check(q, 32'h1, "tx status");
    irq_is(1'b1);
    wr(`SER4_IDX_IEN, 8'h00);
    irq_is(1'b0);
    wr(`SER4_IDX_IEN, 8'h10);
    wr(`SER4_IDX_IMSK, 8'h00);
    irq_is(1'b0);
    wr(`SER4_IDX_IMSK, 8'h01);
    irq_is(1'b1);
    wr(`SER4_IDX_IST, 8'h01);
    irq_is(1'b0);
  endtask

  initial
  begin
    fails = 0;
    n_compared = 0;
    cycles = 0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `SER4_HSIZE_WORD;
    hwdata = 32'h00000000;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_regs;
    t_tx;
    t_mode0;
    t_m0rx;
    t_rx;
    t_irq;
    finish_test;
  end
endmodule
